// ==== iob_buf_if.sv ====
// Interface carrying transfer bytes between the engine and its two-entry buffer.
// Assumes both ends share core_clk.
`timescale 1ns/100ps
interface iob_buf_if;
  logic [7:0] in_data;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] out_data;
  logic       out_valid;
  logic       out_ready;
  modport buf_side (input in_data, input in_valid, output in_ready,
                    output out_data, output out_valid, input out_ready);
  modport eng_side (output in_data, output in_valid, input in_ready,
                    input out_data, input out_valid, output out_ready);
endinterface

// ==== iob_chk_sva.sv ====
// Concurrent checks on the ports of the transfer and interrupt-entry engine.
// Assumes the bind below and a single core_clk domain with srst.
`timescale 1ns/100ps
module iob_chk
  import iob_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        op_valid,
  input wire logic [7:0]  op_code,
  input wire logic        irq_n,
  input wire logic        nmi_n,
  input wire logic [1:0]  irq_mode,
  input wire logic [7:0]  ack_data,
  input wire logic        rd_ack,
  input wire logic        wr_ready,
  input wire logic        busy,
  input wire logic        op_done,
  input wire logic [7:0]  byte_count,
  input wire logic        zero_flag,
  input wire logic        rd_port_req,
  input wire logic        rd_mem_req,
  input wire logic [15:0] rd_addr,
  input wire logic        wr_port_req,
  input wire logic        wr_mem_req,
  input wire logic [15:0] wr_addr,
  input wire logic [7:0]  wr_data,
  input wire logic        opcode_fetch_cycle,
  input wire logic        port_request_strobe,
  input wire logic        irq_acknowledge_cycle,
  input wire logic        restart_valid,
  input wire logic [15:0] restart_addr,
  input wire logic        instr_valid,
  input wire logic [7:0]  instr_byte,
  input wire logic [4:0]  pass_states
);
  import iob_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // An op is only taken with no interrupt pin active, so pending entries cannot steal the edge.
  wire take   = !busy && op_valid && irq_n && nmi_n && op_code[7:5] == 3'h5 && op_code[2:1] == 2'h1;
  wire rd_req = rd_port_req | rd_mem_req;
  wire wr_req = wr_port_req | wr_mem_req;
  sequence ack_seq; opcode_fetch_cycle && port_request_strobe; endsequence
  sequence rd_seq; rd_port_req || rd_mem_req; endsequence
  ack_strobes_a: assert property (irq_acknowledge_cycle |-> ack_seq) else $error("ack strobes apart");
  instr_take_a: assert property (irq_acknowledge_cycle |=> instr_valid && instr_byte == $past(ack_data))
    else $error("ack byte not taken");
  entry_vec_a: assert property (restart_valid |-> restart_addr == VEC_MASKABLE || restart_addr == VEC_NONMASK)
    else $error("bad restart address");
  mode_nmi_a: assert property (restart_valid && irq_mode == IRQ_MODE_INSTR |-> restart_addr == VEC_NONMASK)
    else $error("restart in mode zero");
  zero_done_a: assert property (op_done |-> zero_flag == (byte_count == COUNT_ZERO)) else $error("zero flag");
  final_states_a: assert property (op_done |-> pass_states == STATES_FINAL) else $error("final states");
  op_start_a: assert property (take |-> ##[1:2] rd_seq) else $error("no first read");
  rd_hold_a: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_addr)) else $error("read dropped");
  wr_hold_a: assert property (wr_req && !wr_ready |=> wr_req && $stable(wr_addr) && $stable(wr_data))
    else $error("write dropped");
endmodule
bind iob_engine iob_chk i_chk (.*);

// ==== iob_engine.sv ====
// Port block-transfer engine and interrupt entry of the processor.
// Assumes memory and port handshakes come from logic on core_clk; irq pins are asynchronous.
// Behaviour
// - In mode zero, take the instruction byte driven during the acknowledge cycle.
// - In mode one, an accepted maskable interrupt restarts at address 38 hex.
// - An accepted non-maskable interrupt restarts at address 66 hex in any mode.
// - Read-step-up moves port byte to memory, increments pointer, decrements counter.
// - Read-repeat-up repeats until counter zero; 21 states per repeat, 16 final.
// - Read-step-down moves port byte to memory, decrements pointer and counter.
// - Read-repeat-down repeats the downward step until the counter is zero.
// - Write-step-up moves memory byte to port, increments pointer, decrements counter.
// - Write-repeat-up repeats until counter zero, 21 states per repeated pass.
// - Write-step-down moves memory byte to port, decrements pointer and counter.
// - Write-repeat-down repeats until counter zero, then goes on.
// - Zero flag is set when the decremented counter is zero, else cleared.
`timescale 1ns/100ps
module iob_engine (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             op_valid,
  input  wire logic [7:0]       op_code,
  input  wire logic [15:0]      ptr_in,
  input  wire logic [7:0]       cnt_in,
  input  wire logic [7:0]       port_sel,
  input  wire logic [1:0]       irq_mode,
  input  wire logic             irq_enable,
  input  wire logic             irq_n,
  input  wire logic             nmi_n,
  input  wire logic [7:0]       ack_data,
  input  wire logic             rd_ack,
  input  wire logic [7:0]       rd_data,
  input  wire logic             wr_ready,
  output logic                  busy,
  output logic                  op_done,
  output logic [15:0]           memory_pointer_pair,
  output logic [7:0]            byte_count,
  output logic                  zero_flag,
  output logic                  rd_port_req,
  output logic                  rd_mem_req,
  output logic [15:0]           rd_addr,
  output logic                  wr_port_req,
  output logic                  wr_mem_req,
  output logic [15:0]           wr_addr,
  output logic [7:0]            wr_data,
  output logic                  opcode_fetch_cycle,
  output logic                  port_request_strobe,
  output logic                  irq_acknowledge_cycle,
  output logic                  restart_valid,
  output logic [15:0]           restart_addr,
  output logic                  instr_valid,
  output logic [7:0]            instr_byte,
  output logic                  resume_valid,
  output logic [4:0]            pass_states
);
  import iob_pkg::*;
  typedef enum logic [2:0] {IOB_IDLE, IOB_FETCH, IOB_WAIT, IOB_PUT, IOB_ACK} iob_state_t;

  iob_state_t state_ff;
  iob_op_t    op_ff;
  logic [1:0] irq_sync_ff;
  logic [1:0] nmi_sync_ff;
  logic       nmi_prev_ff;
  logic       nmi_pend_ff;
  logic       int_ack_ff;
  logic       irq_mask_ff;
  logic [15:0] ptr_ff;
  logic [7:0]  cnt_ff;
  logic [15:0] port_addr;

  iob_buf_if bq ();
  iob_skid u_skid (
    .core_clk (core_clk),
    .srst     (srst),
    .bus      (bq)
  );

  function automatic iob_op_t decode_op(input logic [7:0] c);
    unique case (c)
      OP_RD_STEP_UP: decode_op = IOB_RD_STEP_UP;
      OP_RD_REP_UP:  decode_op = IOB_RD_REP_UP;
      OP_RD_STEP_DN: decode_op = IOB_RD_STEP_DN;
      OP_RD_REP_DN:  decode_op = IOB_RD_REP_DN;
      OP_WR_STEP_UP: decode_op = IOB_WR_STEP_UP;
      OP_WR_REP_UP:  decode_op = IOB_WR_REP_UP;
      OP_WR_STEP_DN: decode_op = IOB_WR_STEP_DN;
      OP_WR_REP_DN:  decode_op = IOB_WR_REP_DN;
      default:       decode_op = IOB_NONE;
    endcase
  endfunction

  function automatic logic [15:0] step_ptr(input logic [15:0] p, input iob_op_t o);
    step_ptr = (o inside {IOB_RD_STEP_DN, IOB_RD_REP_DN, IOB_WR_STEP_DN, IOB_WR_REP_DN})
             ? p - PTR_STEP : p + PTR_STEP;
  endfunction

  wire        op_is_read   = op_ff inside {IOB_RD_STEP_UP, IOB_RD_REP_UP, IOB_RD_STEP_DN, IOB_RD_REP_DN};
  wire        op_is_repeat = op_ff inside {IOB_RD_REP_UP, IOB_RD_REP_DN, IOB_WR_REP_UP, IOB_WR_REP_DN};
  wire [7:0]  cnt_dec      = cnt_ff - COUNT_STEP;
  wire        cnt_last     = (cnt_dec == COUNT_ZERO);
  wire [15:0] ptr_next     = step_ptr(ptr_ff, op_ff);
  wire        irq_req      = ~irq_sync_ff[1] && irq_enable && !irq_mask_ff;
  wire        nmi_edge     = nmi_prev_ff && ~nmi_sync_ff[1];
  wire        nmi_any      = nmi_pend_ff || nmi_edge;
  wire        any_int      = nmi_any || irq_req;
  wire        put_accept   = bq.in_valid && bq.in_ready;
  wire        drain_accept = bq.out_valid && bq.out_ready;
  wire        read_ret     = rd_ack && (state_ff == IOB_WAIT);
  assign port_addr = {cnt_ff, port_sel};

  // The byte travels through the buffer so a stalled write target never drops it.
  assign bq.in_data   = rd_data;
  assign bq.in_valid  = read_ret;
  assign bq.out_ready = wr_ready && !wr_port_req && !wr_mem_req;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_sync_ff <= 2'h3;
      nmi_sync_ff <= 2'h3;
      nmi_prev_ff <= 1'b1;
      irq_mask_ff <= 1'b0;
    end else begin
      irq_sync_ff <= {irq_sync_ff[0], irq_n};
      nmi_sync_ff <= {nmi_sync_ff[0], nmi_n};
      nmi_prev_ff <= nmi_sync_ff[1];
      // An accepted maskable entry masks the level input until software drops the enable.
      // Without it a line still low inside the synchroniser would enter a second time.
      if (!irq_enable) irq_mask_ff <= 1'b0;
      else if (irq_req && !nmi_any && state_ff == IOB_IDLE) irq_mask_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= IOB_IDLE;
      op_ff    <= IOB_NONE;
      ptr_ff   <= 16'h0000;
      cnt_ff   <= COUNT_ZERO;
      busy     <= 1'b0;
      op_done  <= 1'b0;
      zero_flag <= 1'b0;
      memory_pointer_pair <= 16'h0000;
      byte_count          <= COUNT_ZERO;
      rd_port_req <= 1'b0;
      rd_mem_req  <= 1'b0;
      rd_addr     <= 16'h0000;
      pass_states <= STATE_ONE;
      nmi_pend_ff <= 1'b0;
      int_ack_ff  <= 1'b0;
      restart_valid <= 1'b0;
      restart_addr  <= 16'h0000;
      instr_valid   <= 1'b0;
      instr_byte    <= 8'h00;
      resume_valid  <= 1'b0;
      opcode_fetch_cycle    <= 1'b0;
      port_request_strobe   <= 1'b0;
      irq_acknowledge_cycle <= 1'b0;
    end else begin
      op_done       <= 1'b0;
      restart_valid <= 1'b0;
      instr_valid   <= 1'b0;
      resume_valid  <= 1'b0;
      if (nmi_edge) nmi_pend_ff <= 1'b1;
      unique case (state_ff)
        IOB_IDLE: begin
          if (any_int) begin
            state_ff <= IOB_ACK;
            busy     <= 1'b1;
            int_ack_ff <= ~nmi_any && (irq_mode == IRQ_MODE_INSTR);
            opcode_fetch_cycle  <= ~nmi_any && (irq_mode == IRQ_MODE_INSTR);
            port_request_strobe <= ~nmi_any && (irq_mode == IRQ_MODE_INSTR);
            irq_acknowledge_cycle <= ~nmi_any && (irq_mode == IRQ_MODE_INSTR);
          end else if (op_valid && decode_op(op_code) != IOB_NONE) begin
            op_ff    <= decode_op(op_code);
            ptr_ff   <= ptr_in;
            cnt_ff   <= cnt_in;
            busy     <= 1'b1;
            state_ff <= IOB_FETCH;
          end
        end
        IOB_FETCH: begin
          // Reads come from the port for input ops and from memory for output ops.
          rd_port_req <= op_is_read;
          rd_mem_req  <= ~op_is_read;
          rd_addr     <= op_is_read ? port_addr : ptr_ff;
          state_ff    <= IOB_WAIT;
        end
        IOB_WAIT: begin
          if (read_ret) begin
            rd_port_req <= 1'b0;
            rd_mem_req  <= 1'b0;
            state_ff    <= IOB_PUT;
          end
        end
        IOB_PUT: begin
          if (!wr_port_req && !wr_mem_req && !bq.out_valid) begin
            ptr_ff    <= ptr_next;
            cnt_ff    <= cnt_dec;
            zero_flag <= cnt_last;
            memory_pointer_pair <= ptr_next;
            byte_count          <= cnt_dec;
            // A repeat pass costs 21 states, the last one 16.
            pass_states <= (op_is_repeat && !cnt_last) ? STATES_REPEAT : STATES_FINAL;
            if (op_is_repeat && !cnt_last) begin
              // Yield between passes; the pending interrupt sees the instruction re-run later.
              if (any_int) begin
                resume_valid <= 1'b1;
                state_ff     <= IOB_IDLE;
                busy         <= 1'b0;
              end else begin
                state_ff <= IOB_FETCH;
              end
            end else begin
              op_done  <= 1'b1;
              state_ff <= IOB_IDLE;
              busy     <= 1'b0;
            end
          end
        end
        IOB_ACK: begin
          opcode_fetch_cycle    <= 1'b0;
          port_request_strobe   <= 1'b0;
          irq_acknowledge_cycle <= 1'b0;
          busy     <= 1'b0;
          state_ff <= IOB_IDLE;
          if (nmi_pend_ff || nmi_edge) begin
            nmi_pend_ff   <= 1'b0;
            restart_valid <= 1'b1;
            restart_addr  <= VEC_NONMASK;
          end else if (int_ack_ff) begin
            instr_valid <= 1'b1;
            instr_byte  <= ack_data;
          end else begin
            restart_valid <= 1'b1;
            restart_addr  <= VEC_MASKABLE;
          end
        end
      endcase
    end
  end

  // Write side drains the buffer toward the port or the memory.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_port_req <= 1'b0;
      wr_mem_req  <= 1'b0;
      wr_addr     <= 16'h0000;
      wr_data     <= 8'h00;
    end else if (wr_port_req || wr_mem_req) begin
      if (wr_ready) begin
        wr_port_req <= 1'b0;
        wr_mem_req  <= 1'b0;
      end
    end else if (drain_accept) begin
      wr_port_req <= ~op_is_read;
      wr_mem_req  <= op_is_read;
      wr_addr     <= op_is_read ? ptr_ff : port_addr;
      wr_data     <= bq.out_data;
    end
  end

  initial begin
    if ($bits(ptr_in) != 16) $error("Pointer width must be 16.");
  end
  wire unused_accept = put_accept;
endmodule

// ==== iob_far.sv ====
// Far-side model: port devices, memory and the interrupting device.
// Assumes requests are held until acknowledged; slow adds wait cycles.
`timescale 1ns/100ps
module iob_far (
  input  wire logic        core_clk,
  input  wire logic        slow,
  input  wire logic        rd_port_req,
  input  wire logic        rd_mem_req,
  input  wire logic [15:0] rd_addr,
  output logic             rd_ack,
  output logic [7:0]       rd_data,
  input  wire logic        wr_port_req,
  input  wire logic        wr_mem_req,
  output logic             wr_ready,
  input  wire logic        irq_acknowledge_cycle,
  output logic [7:0]       ack_data
);
  localparam logic [7:0] INSTR = 8'hC7;
  logic [7:0] spin_ff = 8'h00;
  logic [1:0] wait_ff = 2'h0;
  logic       ack_ff  = 1'b0;
  wire want = rd_port_req | rd_mem_req;
  assign rd_ack = ack_ff;
  always @(posedge core_clk) begin
    spin_ff <= spin_ff + 8'h35;
    wait_ff <= (want && !ack_ff) ? wait_ff + 2'h1 : 2'h0;
    ack_ff  <= want && !ack_ff && (!slow || wait_ff == 2'h3);
  end
  // Outside an answer the lines churn, so a stale byte can never look right.
  assign rd_data  = !rd_ack ? spin_ff : rd_port_req ? rd_addr[7:0] ^ rd_addr[15:8] ^ 8'h3C : rd_addr[7:0] + 8'h11;
  assign wr_ready = !slow | spin_ff[6];
  assign ack_data = irq_acknowledge_cycle ? INSTR : ~spin_ff;
endmodule

// ==== iob_pkg.sv ====
// Package for the port block-transfer and interrupt-entry engine.
// Assumes a single 25 MHz core clock and byte-wide port and memory buses.
package iob_pkg;
  localparam logic [7:0]  OP_PREFIX_ED   = 8'hED;
  localparam logic [7:0]  OP_RD_STEP_UP  = 8'hA2;
  localparam logic [7:0]  OP_RD_REP_UP   = 8'hB2;
  localparam logic [7:0]  OP_RD_STEP_DN  = 8'hAA;
  localparam logic [7:0]  OP_RD_REP_DN   = 8'hBA;
  localparam logic [7:0]  OP_WR_STEP_UP  = 8'hA3;
  localparam logic [7:0]  OP_WR_REP_UP   = 8'hB3;
  localparam logic [7:0]  OP_WR_STEP_DN  = 8'hAB;
  localparam logic [7:0]  OP_WR_REP_DN   = 8'hBB;
  localparam logic [15:0] VEC_MASKABLE   = 16'h0038;
  localparam logic [15:0] VEC_NONMASK    = 16'h0066;
  localparam logic [1:0]  IRQ_MODE_INSTR = 2'h0;
  localparam logic [1:0]  IRQ_MODE_FIXED = 2'h1;
  localparam logic [4:0]  STATES_REPEAT  = 5'h15;
  localparam logic [4:0]  STATES_FINAL   = 5'h10;
  localparam logic [7:0]  COUNT_ZERO     = 8'h00;
  localparam logic [15:0] PTR_STEP       = 16'h0001;
  localparam logic [7:0]  COUNT_STEP     = 8'h01;
  localparam logic [4:0]  STATE_ONE      = 5'h01;
  typedef enum logic [3:0] {
    IOB_RD_STEP_UP, IOB_RD_REP_UP, IOB_RD_STEP_DN, IOB_RD_REP_DN,
    IOB_WR_STEP_UP, IOB_WR_REP_UP, IOB_WR_STEP_DN, IOB_WR_REP_DN, IOB_NONE
  } iob_op_t;
endpackage

// ==== iob_skid.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module iob_skid (
  input  wire logic core_clk,
  input  wire logic srst,
  iob_buf_if.buf_side bus
);
  import iob_pkg::*;
  logic [7:0] mem_ff [2];
  logic       wr_ptr_ff;
  logic       rd_ptr_ff;
  logic [1:0] fill_ff;
  wire push = bus.in_valid && bus.in_ready;
  wire pop  = bus.out_valid && bus.out_ready;
  assign bus.in_ready  = (fill_ff != 2'h2);
  assign bus.out_valid = (fill_ff != 2'h0);
  assign bus.out_data  = mem_ff[rd_ptr_ff];
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      fill_ff   <= 2'h0;
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= bus.in_data;
        wr_ptr_ff         <= ~wr_ptr_ff;
      end
      if (pop) rd_ptr_ff <= ~rd_ptr_ff;
      fill_ff <= fill_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ==== tb_top.sv ====
// Bench for the transfer engine: drives ops and interrupt pins, checks results in order.
// Assumes iob_far on the far side and iob_chk bound to iob_engine.
`timescale 1ns/100ps
module tb_top;
  import iob_pkg::*;
  logic        core_clk = 1'b0, srst = 1'b1, op_valid = 1'b0, slow = 1'b0;
  logic        irq_enable = 1'b0, irq_n = 1'b1, nmi_n = 1'b1;
  logic [7:0]  op_code = 8'h00, cnt_in = 8'h00, port_sel = 8'h00;
  logic [15:0] ptr_in = 16'h0000;
  logic [1:0]  irq_mode = 2'h0;
  wire  [7:0]  ack_data, rd_data, byte_count, wr_data, instr_byte;
  wire  [15:0] memory_pointer_pair, rd_addr, wr_addr, restart_addr;
  wire  [4:0]  pass_states;
  wire         rd_ack, wr_ready, busy, op_done, zero_flag, rd_port_req, rd_mem_req, wr_port_req, wr_mem_req;
  wire         opcode_fetch_cycle, port_request_strobe, irq_acknowledge_cycle, restart_valid, instr_valid;
  wire         resume_valid;
  int          failures = 0, total_checks = 0, seed = 10, i;
  logic [24:0] wq[$];
  logic [29:0] dq[$];
  logic [15:0] eq[$];
  logic [7:0]  ops[8] = '{OP_RD_STEP_UP, OP_RD_REP_UP, OP_RD_STEP_DN, OP_RD_REP_DN,
                          OP_WR_STEP_UP, OP_WR_REP_UP, OP_WR_STEP_DN, OP_WR_REP_DN};
  iob_engine i_dut (.*);
  iob_far i_far (.*);
  always #20 core_clk = ~core_clk;
  task automatic tally(input logic hit, input string what);
    total_checks++;
    if (hit !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_xfer(input logic [24:0] got);
    tally(wq.size() != 0 && got === wq.pop_front(), "transfer");
  endtask
  task automatic cmp_done(input logic [29:0] got);
    tally(dq.size() != 0 && got === dq.pop_front(), "pointer, count or flag");
  endtask
  task automatic cmp_entry(input logic [15:0] got);
    tally(eq.size() != 0 && got === eq.pop_front(), "interrupt entry");
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait on negedges until the named queue drains or busy clears.
  task automatic settle(input int which);
    for (int n = 0; which == 0 ? busy !== 1'b0 : which == 1 ? dq.size() != 0 : eq.size() != 0; n++) begin
      @(negedge core_clk);
      if (n > 2000) begin
        failures++;
        test_done();
      end
    end
  endtask
  task automatic issue(input logic [7:0] op, input logic [15:0] p, input logic [7:0] c);
    settle(0);
    op_code = op;
    ptr_in = p;
    cnt_in = c;
    op_valid = 1'b1;
    @(negedge core_clk);
    op_valid = 1'b0;
  endtask
  task automatic run_op(input logic [7:0] op, input logic [15:0] p, input logic [7:0] c, input bit yield);
    logic [15:0] a;
    logic [7:0]  k;
    a = p;
    k = c;
    port_sel = 8'($random(seed));
    for (int n = 0; n < (op[4] ? int'(c) : 1); n++) begin
      wq.push_back(!op[0] ? {1'b0, a, a[7:0] + 8'h11} : {1'b1, k, port_sel, a[7:0] + 8'h11});
      if (!op[0]) wq[$] = {1'b0, a, k ^ port_sel ^ 8'h3C};
      a = op[3] ? a - 16'h0001 : a + 16'h0001;
      k = k - 8'h01;
    end
    dq.push_back({a, k, k == 8'h00, STATES_FINAL});
    issue(op, p, c);
    if (yield) begin
      eq.push_back(VEC_NONMASK);
      nmi_n = 1'b0;
      for (int n = 0; resume_valid !== 1'b1; n++) begin
        @(negedge core_clk);
        if (n == 4) nmi_n = 1'b1;
        if (n > 400) begin
          failures++;
          test_done();
        end
      end
      nmi_n = 1'b1;
      // The restart entry is served before the host re-issues the op.
      settle(2);
      issue(op, memory_pointer_pair, byte_count);
    end else begin
      // A second request while busy must be ignored.
      @(negedge core_clk);
      op_valid = 1'b1;
      @(negedge core_clk);
      op_valid = 1'b0;
    end
    settle(1);
    tally(wq.size() == 0, "missing transfer");
    $display("op %h count %0d finished", op, c);
  endtask
  task automatic irq_case(input logic [1:0] m, input logic en, input logic nmi);
    irq_mode = m;
    irq_enable = en;
    if (nmi || en) eq.push_back(nmi ? VEC_NONMASK : m == IRQ_MODE_FIXED ? VEC_MASKABLE : {8'h00, 8'hC7});
    if (nmi) nmi_n = 1'b0;
    else irq_n = 1'b0;
    repeat (3) @(negedge core_clk);
    settle(2);
    irq_enable = 1'b0;
    irq_n = 1'b1;
    nmi_n = 1'b1;
    repeat (10) @(negedge core_clk);
    tally(eq.size() == 0, "entry count");
    $display("interrupt mode %0d enable %0d nmi %0d finished", m, en, nmi);
  endtask
  always @(negedge core_clk) begin
    if (!srst) begin
      if ((wr_port_req | wr_mem_req) && wr_ready) cmp_xfer({wr_port_req, wr_addr, wr_data});
      if (op_done) cmp_done({memory_pointer_pair, byte_count, zero_flag, pass_states});
      if (restart_valid) cmp_entry(restart_addr);
      if (instr_valid) cmp_entry({8'h00, instr_byte});
    end
  end
  initial begin
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    for (i = 0; i < 16; i++) begin
      slow = i[3];
      run_op(ops[i % 8], 16'($random(seed)), 8'h01 + 8'($random(seed) & 3), 1'b0);
    end
    run_op(OP_RD_REP_DN, 16'h8000, 8'h04, 1'b1);
    run_op(OP_WR_REP_UP, 16'hFFFE, 8'h04, 1'b1);
    slow = 1'b0;
    irq_case(IRQ_MODE_INSTR, 1'b1, 1'b0);
    irq_case(IRQ_MODE_FIXED, 1'b1, 1'b0);
    irq_case(IRQ_MODE_FIXED, 1'b0, 1'b0);
    irq_case(IRQ_MODE_INSTR, 1'b0, 1'b1);
    irq_case(IRQ_MODE_FIXED, 1'b0, 1'b1);
    test_done();
  end
endmodule
